// >>> rtl/ccs_clk_div.sv
`timescale 1ns/1ns
`include "ccs_defs.svh"

module ccs_clk_div (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  import ccs_pkg::*;

  logic [1:0] cnt_r;

  // internal clock enable at half rate
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_r <= 2'h0;
    end else if (cnt_r == 2'(`CCS_INT_CLK_DIV - 1)) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  assign o_tick = (cnt_r == 2'(`CCS_INT_CLK_DIV - 1));

endmodule : ccs_clk_div

// >>> rtl/ccs_cmd_status.sv
// Notes on behaviour
// - command register reads back all zero
// - command bit four requests loopback transmission
// - loopback stores own frame only if accepted
// - send plus abort gives single shot
// - loopback plus abort gives single shot loopback
// - send, abort, loopback acts as single shot
// - send with loopback ignores the loopback
// - pending request clears when sending starts
// - clear overrun command clears overrun flag
// - free slot command releases one queue message
// - abort cancels only a not started request
// - aborted message still gives a transmit event
// - writing zero never cancels a send request
// - status bit seven shows offline state
// - bit six shows either counter at or above warning threshold
// - bits five, four show sending and receiving
// - bit three shows last transmission succeeded
// - bit two shows send buffer free
// - bit one sticks on lost message
// - bit zero shows messages waiting in queue
// - send or loopback request clears done flag
// - writes to locked send buffer are dropped
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "ccs_defs.svh"

module ccs_cmd_status (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic [`CCS_ADDR_W-1:0]    i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [7:0]                     o_rdata,
  input  wire ccs_pkg::ccs_proto_st_t    i_proto_st,
  input  wire ccs_pkg::ccs_proto_ev_t    i_proto_ev,
  output logic                           o_tx_start,
  output ccs_pkg::ccs_tx_req_t           o_tx_req,
  output logic                           o_tx_event,
  output logic                           o_rx_event,
  output logic                           o_overrun_event,
  output logic [7:0]                     o_tx_buf_byte,
  output logic                           o_int_tick
);
  import ccs_pkg::*;

  logic                       cmd_wr;
  logic [7:0]                 cmd;
  logic                       cmd_pend_r;
  logic [7:0]                 cmd_r;
  logic                       cmd_fire;
  logic                       req_send;
  logic                       req_loop;
  logic                       req_abort;
  logic                       tick;
  ccs_tx_state_t              tx_state_r;
  ccs_tx_state_t              tx_state_nxt;
  ccs_tx_req_t                tx_req_r;
  logic                       sending_q_r;
  logic                       send_done_r;
  logic                       overrun_r;
  logic [7:0]                 warn_thr_r;
  logic [7:0]                 tx_buf_r;
  logic                       rx_ready;
  logic [`CCS_RXQ_CNT_W-1:0]  rxq_count;
  logic                       rx_drop;
  logic                       rx_store;
  logic                       free_rx;
  logic                       clr_ovr;
  logic                       warning;
  logic                       buf_free;
  logic                       tx_end;
  logic [7:0]                 status;

  ccs_clk_div u_clk_div (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );

  assign o_int_tick = tick;
  assign cmd_wr     = i_wr && (i_addr == `CCS_IDX_CMD);

  // command strobe captured, then acted on at the next internal clock edge
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_pend_r <= 1'b0;
      cmd_r      <= 8'h00;
    end else if (cmd_wr) begin
      cmd_pend_r <= 1'b1;
      cmd_r      <= i_wdata;
    end else if (tick) begin
      cmd_pend_r <= 1'b0;
      cmd_r      <= 8'h00;
    end
  end

  // one internal cycle between commands is assumed of the host
  assign cmd_fire  = cmd_pend_r && tick;
  assign cmd       = cmd_fire ? cmd_r : 8'h00;
  assign req_abort = cmd[`CCS_CMD_ABORT];
  assign req_send  = cmd[`CCS_CMD_SEND];
  assign req_loop  = cmd[`CCS_CMD_LOOPBACK] && !cmd[`CCS_CMD_SEND];
  assign free_rx   = cmd[`CCS_CMD_FREE_RX];
  assign clr_ovr   = cmd[`CCS_CMD_CLR_OVR];

  assign tx_end = i_proto_ev.tx_ok || i_proto_ev.tx_fail || i_proto_ev.tx_arb_lost;

  // transmit request state
  always_comb begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      CCS_TX_IDLE: begin
        if (req_send || req_loop) begin
          tx_state_nxt = CCS_TX_PENDING;
        end
      end
      CCS_TX_PENDING: begin
        if (req_abort && !(req_send || req_loop)) begin
          tx_state_nxt = CCS_TX_IDLE;
        end else if (i_proto_st.sending) begin
          tx_state_nxt = CCS_TX_ACTIVE;
        end
      end
      CCS_TX_ACTIVE: begin
        // abort does not stop an active frame
        if (i_proto_ev.tx_ok) begin
          tx_state_nxt = CCS_TX_IDLE;
        end else if (tx_end) begin
          tx_state_nxt = tx_req_r.single_shot ? CCS_TX_IDLE : CCS_TX_PENDING;
        end
      end
      default: begin
        tx_state_nxt = CCS_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_state_r <= CCS_TX_IDLE;
    end else begin
      tx_state_r <= tx_state_nxt;
    end
  end

  // request flavour; zero bits never cancel
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_req_r <= '0;
    end else if (tx_state_r == CCS_TX_IDLE && (req_send || req_loop)) begin
      tx_req_r.loopback    <= req_loop;
      tx_req_r.single_shot <= req_abort;
    end
  end

  assign o_tx_start = (tx_state_r == CCS_TX_PENDING) && !i_proto_st.sending;
  assign o_tx_req   = tx_req_r;

  // transmit event on success or on buffer release after abort
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tx_event <= 1'b0;
    end else begin
      o_tx_event <= (tx_state_r != CCS_TX_IDLE) && (tx_state_nxt == CCS_TX_IDLE);
    end
  end

  // send done flag
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      send_done_r <= 1'b1;
    end else if (req_send || req_loop) begin
      send_done_r <= 1'b0;
    end else if (tx_state_r == CCS_TX_ACTIVE && i_proto_ev.tx_ok) begin
      send_done_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sending_q_r <= 1'b0;
    end else begin
      sending_q_r <= i_proto_st.sending;
    end
  end

  // own loopback frame goes in only when the filter accepts it
  assign rx_store = i_proto_ev.rx_frame_ok && i_proto_ev.rx_accepted;

  ccs_rx_queue_ctr u_rxq (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_store   (rx_store),
    .i_free    (free_rx),
    .o_count   (rxq_count),
    .o_ready   (rx_ready),
    .o_drop    (rx_drop)
  );

  // rx event follows a stored frame, loopback completes with tx and rx events
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rx_event <= 1'b0;
    end else begin
      o_rx_event <= rx_store && !rx_drop;
    end
  end

  // overrun flag, set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      overrun_r <= 1'b0;
    end else if (rx_drop) begin
      overrun_r <= 1'b1;
    end else if (clr_ovr) begin
      overrun_r <= 1'b0;
    end
  end

  // overrun event only on rising flag
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_overrun_event <= 1'b0;
    end else begin
      o_overrun_event <= rx_drop && !overrun_r;
    end
  end

  // warning threshold register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      warn_thr_r <= `CCS_WARN_THR_RST;
    end else if (i_wr && i_addr == `CCS_IDX_WARN_THR) begin
      warn_thr_r <= i_wdata;
    end
  end

  assign warning  = (i_proto_st.tx_err_cnt >= warn_thr_r) ||
                    (i_proto_st.rx_err_cnt >= warn_thr_r);
  assign buf_free = (tx_state_r == CCS_TX_IDLE);

  // send buffer byte, locked writes dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_buf_r <= `CCS_TX_BUF_RST;
    end else if (i_wr && i_addr == `CCS_IDX_TX_BUF && buf_free) begin
      tx_buf_r <= i_wdata;
    end
  end

  assign o_tx_buf_byte = tx_buf_r;

  // status assembly
  always_comb begin
    status                     = 8'h00;
    status[`CCS_ST_OFFLINE]    = i_proto_st.offline;
    status[`CCS_ST_WARNING]    = warning;
    status[`CCS_ST_SENDING]    = sending_q_r;
    status[`CCS_ST_RECEIVING]  = i_proto_st.receiving;
    status[`CCS_ST_SEND_DONE]  = send_done_r;
    status[`CCS_ST_BUF_FREE]   = buf_free;
    status[`CCS_ST_OVERRUN]    = overrun_r;
    status[`CCS_ST_RX_READY]   = rx_ready;
  end

  // read data one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `CCS_IDX_CMD:       o_rdata <= 8'h00;
        `CCS_IDX_STATUS:    o_rdata <= status;
        `CCS_IDX_WARN_THR:  o_rdata <= warn_thr_r;
        `CCS_IDX_TX_BUF:    o_rdata <= tx_buf_r;
        `CCS_IDX_RXQ_COUNT: o_rdata <= 8'(rxq_count);
        default:            o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : ccs_cmd_status

// >>> rtl/ccs_defs.svh
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// register indices; byte address is four times the index
`define CCS_IDX_CMD          8'h01
`define CCS_IDX_STATUS       8'h02
`define CCS_IDX_WARN_THR     8'h06
`define CCS_IDX_TX_BUF       8'h0A
`define CCS_IDX_RXQ_COUNT    8'h1D
`define CCS_ADDR_W           8

// command bit positions
`define CCS_CMD_SEND         0
`define CCS_CMD_ABORT        1
`define CCS_CMD_FREE_RX      2
`define CCS_CMD_CLR_OVR      3
`define CCS_CMD_LOOPBACK     4

// status bit positions
`define CCS_ST_RX_READY      0
`define CCS_ST_OVERRUN       1
`define CCS_ST_BUF_FREE      2
`define CCS_ST_SEND_DONE     3
`define CCS_ST_RECEIVING     4
`define CCS_ST_SENDING       5
`define CCS_ST_WARNING       6
`define CCS_ST_OFFLINE       7

// reset values
`define CCS_WARN_THR_RST     8'h60
`define CCS_STATUS_RST       8'h0C
`define CCS_TX_BUF_RST       8'h00

// receive queue geometry
`define CCS_RXQ_DEPTH        4
`define CCS_RXQ_CNT_W        3

// internal clock is half the system clock
`define CCS_INT_CLK_DIV      2

`endif

// >>> rtl/ccs_pkg.sv
package ccs_pkg;

  typedef struct packed {
    logic       loopback;
    logic       single_shot;
  } ccs_tx_req_t;

  typedef struct packed {
    logic       sending;
    logic       receiving;
    logic       offline;
    logic [7:0] tx_err_cnt;
    logic [7:0] rx_err_cnt;
  } ccs_proto_st_t;

  typedef struct packed {
    logic       tx_ok;
    logic       tx_fail;
    logic       tx_arb_lost;
    logic       rx_frame_ok;
    logic       rx_accepted;
  } ccs_proto_ev_t;

  typedef enum logic [1:0] {
    CCS_TX_IDLE,
    CCS_TX_PENDING,
    CCS_TX_ACTIVE
  } ccs_tx_state_t;

endpackage : ccs_pkg

// >>> rtl/ccs_rx_queue_ctr.sv
`timescale 1ns/1ns
`include "ccs_defs.svh"

module ccs_rx_queue_ctr (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_store,
  input  wire logic                      i_free,
  output logic [`CCS_RXQ_CNT_W-1:0]      o_count,
  output logic                           o_ready,
  output logic                           o_drop
);
  import ccs_pkg::*;

  logic                      full;
  logic                      do_store;
  logic                      do_free;

  assign full     = (o_count == `CCS_RXQ_CNT_W'(`CCS_RXQ_DEPTH));
  assign do_store = i_store && (!full || i_free);
  assign do_free  = i_free && (o_count != `CCS_RXQ_CNT_W'(0));
  assign o_drop   = i_store && full && !i_free;

  // message count of the queue
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_count <= `CCS_RXQ_CNT_W'(0);
    end else if (do_store && !do_free) begin
      o_count <= o_count + `CCS_RXQ_CNT_W'(1);
    end else if (do_free && !do_store) begin
      o_count <= o_count - `CCS_RXQ_CNT_W'(1);
    end
  end

  assign o_ready = (o_count != `CCS_RXQ_CNT_W'(0));

endmodule : ccs_rx_queue_ctr

// >>> test/ccs_cmd_status_asserts.sv
`timescale 1ns/1ns

module ccs_cmd_status_asserts (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst,
  input wire logic [7:0]             i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [7:0]             o_rdata,
  input wire ccs_pkg::ccs_proto_st_t i_proto_st,
  input wire ccs_pkg::ccs_proto_ev_t i_proto_ev,
  input wire logic                   o_tx_start,
  input wire ccs_pkg::ccs_tx_req_t   o_tx_req,
  input wire logic                   o_rx_event,
  input wire logic                   o_overrun_event,
  input wire logic                   o_int_tick
);
  import ccs_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence cmd_s(logic [7:0] c);
    i_wr && i_addr == 8'h01 && i_wdata == c && !o_tx_start;
  endsequence
  sequence st_rd_s;
    i_rd && i_addr == 8'h02;
  endsequence

  cmd_read_a: assert property (i_rd && i_addr == 8'h01 |=> o_rdata == 8'h00)
    else $error("command read not zero");
  tick_alt_a: assert property (o_int_tick |=> !o_int_tick ##1 o_int_tick)
    else $error("internal tick not every second cycle");
  loop_req_a: assert property (cmd_s(8'h10) |-> ##[1:3] (o_tx_start && o_tx_req == 2'b10))
    else $error("loopback request wrong");
  single_req_a: assert property (cmd_s(8'h03) |-> ##[1:3] (o_tx_start && o_tx_req == 2'b01))
    else $error("single shot request wrong");
  send_loop_a: assert property (cmd_s(8'h11) |-> ##[1:3] (o_tx_start && o_tx_req == 2'b00))
    else $error("loopback not ignored");
  start_hold_a: assert property ((i_proto_st.sending || i_proto_ev.tx_ok) |-> !o_tx_start)
    else $error("start while sending");
  rx_cause_a: assert property (o_rx_event |-> $past(i_proto_ev.rx_frame_ok && i_proto_ev.rx_accepted))
    else $error("frame stored without acceptance");
  ovr_once_a: assert property (o_overrun_event |=> !o_overrun_event)
    else $error("overrun event repeated");
  offline_bit_a: assert property (st_rd_s |=> o_rdata[7] == $past(i_proto_st.offline))
    else $error("offline bit wrong");
  recv_bit_a: assert property (st_rd_s |=> o_rdata[4] == $past(i_proto_st.receiving))
    else $error("receiving bit wrong");
endmodule : ccs_cmd_status_asserts

bind ccs_cmd_status ccs_cmd_status_asserts u_ccs_cmd_status_asserts (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_proto_st(i_proto_st), .i_proto_ev(i_proto_ev),
  .o_tx_start(o_tx_start), .o_tx_req(o_tx_req), .o_rx_event(o_rx_event),
  .o_overrun_event(o_overrun_event), .o_int_tick(o_int_tick));

// >>> test/ccs_proto_model.sv
`timescale 1ns/1ns

module ccs_proto_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_fail,
  input  wire logic i_slow,
  output logic      o_sending,
  output logic      o_ok,
  output logic      o_bad
);
  logic [3:0] cnt_r;

  // frame takes eight cycles on the wire
  always_ff @(posedge i_clk) begin
    o_ok <= 1'b0;
    o_bad <= 1'b0;
    if (i_rst || (!o_sending && !i_start)) begin
      cnt_r <= 4'h0;
      o_sending <= 1'b0;
    end else if (!o_sending) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r >= (i_slow ? 4'h8 : 4'h0)) begin
        o_sending <= 1'b1;
        cnt_r <= 4'h0;
      end
    end else begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h7) begin
        o_sending <= 1'b0;
        o_ok <= !i_fail;
        o_bad <= i_fail;
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : ccs_proto_model

// >>> test/tb_top.sv
`timescale 1ns/1ns

module tb_top;
  import ccs_pkg::*;
  logic          i_sys_clk = 1'b0;
  logic          i_rst     = 1'b1;
  logic [7:0]    i_addr    = 8'h00;
  logic [7:0]    i_wdata   = 8'h00;
  logic          i_wr      = 1'b0;
  logic          i_rd      = 1'b0;
  logic          rx_ok     = 1'b0;
  logic          rx_acc    = 1'b0;
  logic          recv      = 1'b0;
  logic          offl      = 1'b0;
  logic          fail      = 1'b0;
  logic          slow      = 1'b0;
  logic          lost      = 1'b0;
  logic [7:0]    terr      = 8'h00;
  logic [7:0]    rerr      = 8'h00;
  logic [7:0]    o_rdata, o_tx_buf_byte;
  logic          o_tx_start, o_tx_event, o_rx_event, o_overrun_event, o_int_tick;
  logic          m_snd, m_ok, m_bad;
  ccs_tx_req_t   o_tx_req;
  ccs_proto_st_t i_proto_st;
  ccs_proto_ev_t i_proto_ev;
  int            err_total = 0;
  int            n_checks  = 0;

  assign i_proto_st = '{m_snd, recv, offl, terr, rerr};
  assign i_proto_ev = '{m_ok, m_bad && !lost, m_bad && lost, rx_ok, rx_acc};
  always #5 i_sys_clk = ~i_sys_clk;

  ccs_cmd_status u_ccs_cmd_status (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_proto_st(i_proto_st),
    .i_proto_ev(i_proto_ev), .o_tx_start(o_tx_start), .o_tx_req(o_tx_req),
    .o_tx_event(o_tx_event), .o_rx_event(o_rx_event), .o_overrun_event(o_overrun_event),
    .o_tx_buf_byte(o_tx_buf_byte), .o_int_tick(o_int_tick));
  ccs_proto_model u_ccs_proto_model (.i_clk(i_sys_clk), .i_rst(i_rst), .i_start(o_tx_start),
    .i_fail(fail), .i_slow(slow), .o_sending(m_snd), .o_ok(m_ok), .o_bad(m_bad));

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // lead of two cycles lets a command land first
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    repeat (2) @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask : rd

  task automatic rx(input logic a);
    @(posedge i_sys_clk);
    rx_ok <= 1'b1;
    rx_acc <= a;
    @(posedge i_sys_clk);
    rx_ok <= 1'b0;
    rx_acc <= 1'b0;
  endtask : rx

  // w: 0 transmit event, 1 start, 2 engine sending
  task automatic wait_for(input int w);
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge i_sys_clk);
      #1;
      if ((w == 0) ? o_tx_event === 1'b1 : (w == 1) ? o_tx_start === 1'b1 : m_snd === 1'b1) break;
    end
    if (k == 60) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      final_report();
    end
  endtask : wait_for

  task automatic t_reset;
    rd(8'h02, 8'hFF, 8'h0C);
    rd(8'h01, 8'hFF, 8'h00);
    rd(8'h30, 8'hFF, 8'h00);
    wr(8'h01, 8'hE0);
    rd(8'h02, 8'hFF, 8'h0C);
    $display("test reset done");
  endtask : t_reset

  task automatic t_send;
    slow <= 1'b1;
    wr(8'h01, 8'h01);
    wr(8'h01, 8'h00);
    rd(8'h02, 8'h0C, 8'h00);
    wait_for(0);
    rd(8'h02, 8'hFF, 8'h0C);
    wr(8'h01, 8'h01);
    wr(8'h01, 8'h02);
    wait_for(0);
    rd(8'h02, 8'h2C, 8'h04);
    slow <= 1'b0;
    wr(8'h01, 8'h01);
    wait_for(2);
    rd(8'h02, 8'h2C, 8'h20);
    wr(8'h01, 8'h02);
    wait_for(0);
    rd(8'h02, 8'h0C, 8'h0C);
    $display("test send and abort done");
  endtask : t_send

  task automatic t_modes;
    logic [7:0] cmd [5] = '{8'h03, 8'h12, 8'h13, 8'h11, 8'h10};
    logic [7:0] req [5] = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h02};
    for (int i = 0; i < 5; i++) begin
      fail <= req[i][0];
      lost <= (i == 2);
      wr(8'h01, cmd[i]);
      wait_for(1);
      chk({6'h00, o_tx_req}, req[i]);
      wait_for(0);
      chk({7'h00, o_tx_start}, 8'h00);
      rd(8'h02, 8'h0C, req[i][0] ? 8'h04 : 8'h0C);
    end
    fail <= 1'b0;
    lost <= 1'b0;
    $display("test modes done");
  endtask : t_modes

  task automatic t_rx;
    rx(1'b0);
    #1 chk({6'h00, o_rx_event, o_overrun_event}, 8'h00);
    rd(8'h02, 8'h01, 8'h00);
    rx(1'b1);
    #1 chk({6'h00, o_rx_event, o_overrun_event}, 8'h02);
    repeat (3) rx(1'b1);
    rd(8'h02, 8'h03, 8'h01);
    rx(1'b1);
    #1 chk({6'h00, o_rx_event, o_overrun_event}, 8'h01);
    rx(1'b1);
    #1 chk({6'h00, o_rx_event, o_overrun_event}, 8'h00);
    rd(8'h02, 8'h03, 8'h03);
    wr(8'h01, 8'h08);
    rd(8'h02, 8'h03, 8'h01);
    repeat (3) wr(8'h01, 8'h04);
    rd(8'h02, 8'h01, 8'h01);
    wr(8'h01, 8'h04);
    rd(8'h02, 8'h01, 8'h00);
    $display("test receive done");
  endtask : t_rx

  task automatic t_levels;
    offl <= 1'b1;
    recv <= 1'b1;
    terr <= 8'h60;
    rd(8'h02, 8'hFF, 8'hDC);
    offl <= 1'b0;
    recv <= 1'b0;
    terr <= 8'h5F;
    rerr <= 8'h5F;
    rd(8'h02, 8'hFF, 8'h0C);
    rerr <= 8'h60;
    rd(8'h02, 8'hFF, 8'h4C);
    wr(8'h06, 8'h70);
    rd(8'h02, 8'hFF, 8'h0C);
    $display("test levels done");
  endtask : t_levels

  task automatic t_buf;
    wr(8'h0A, 8'h5A);
    #1 chk(o_tx_buf_byte, 8'h5A);
    slow <= 1'b1;
    wr(8'h01, 8'h01);
    repeat (3) @(posedge i_sys_clk);
    wr(8'h0A, 8'hA5);
    #1 chk(o_tx_buf_byte, 8'h5A);
    wait_for(0);
    $display("test send buffer done");
  endtask : t_buf

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_send();
    t_modes();
    t_rx();
    t_levels();
    t_buf();
    final_report();
  end
endmodule : tb_top
